// ==== sca_admit.sv ====
// command admission and unit attention top
//
// Behaviour
// - idle target runs a new command unless a higher condition blocks it
// - startup or format active: other commands get check condition, not ready sense key
// - pending unit attention outranks not ready during startup or format
// - priority command runs concurrently when concurrency conditions hold
// - command queued when a process exists and connection is correct
// - task set full when queue or unreserved slots are all occupied
// - task set full while a queued format has not started
// - degraded mode: task set full while queued start unit waits
// - busy only for initiators beyond the first 64 seen since power on
// - any reset creates a unit attention for every initiator
// - mode select setting pages: attention for all but the issuer
// - no mode attention on early error or header-only parameter list
// - format completion: attention for all but the issuer
// - microcode download completion: attention for all but the issuer
// - clear task set: attention for others with active or queued work
// - log select parameter clear: attention for all but the issuer
// - persistent reservation cleared by another: attention for the holder
// - failure threshold with reporting method 2h creates an attention
// - attentions kept per initiator, accumulate, persist until cleared
// - inquiry and report luns run with good status, attention kept
// - request sense returns other sense and keeps, else clears top one
// - other commands get check condition and clear top attention
// - blocking conditions checked in fixed order, only highest reported
// - status bytes: 02h check, 08h busy, 28h task set full
`timescale 1ns/1ps
module sca_admit
  import sca_pkg::*;
#(
  parameter int NINIT = NUM_INIT,
  parameter int QSIZE = QUEUE_DEPTH,
  parameter int BLIM  = BUSY_LIMIT
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  // new command
  input  wire logic                     cmd_valid_i,
  input  wire logic [$clog2(NINIT)-1:0] cmd_init_i,
  input  wire logic                     cmd_new_init_i,
  input  wire sca_cmd_type              cmd_kind_i,
  input  wire logic                     cmd_priority_i,
  input  wire logic                     cmd_lun_bad_i,
  input  wire logic                     cmd_bad_conn_i,
  input  wire logic                     cmd_sense_pend_i,
  input  wire logic                     cmd_deferred_i,
  input  wire logic                     cmd_res_conf_i,
  input  wire logic                     cmd_bad_op_i,
  input  wire logic                     cmd_bad_cdb_i,
  // target state
  input  wire logic                     io_active_i,
  input  wire logic                     conc_ok_i,
  input  wire logic [$clog2(QSIZE):0]   q_used_i,
  input  wire logic [$clog2(QSIZE):0]   q_free_own_i,
  input  wire logic                     q_format_wait_i,
  input  wire logic                     q_start_wait_i,
  input  wire logic                     degraded_i,
  input  wire logic                     not_ready_i,
  // attention events
  input  wire logic                     ev_lun_reset_i,
  input  wire logic                     ev_mode_set_i,
  input  wire logic                     ev_mode_err_i,
  input  wire logic                     ev_mode_hdr_only_i,
  input  wire logic                     ev_format_done_i,
  input  wire logic                     ev_micro_done_i,
  input  wire logic                     ev_log_clear_i,
  input  wire logic                     log_param_clear_bit_i,
  input  wire logic                     ev_clear_task_i,
  input  wire logic [NINIT-1:0]         ev_clear_mask_i,
  input  wire logic                     ev_pr_lost_i,
  input  wire logic [$clog2(NINIT)-1:0] ev_holder_i,
  input  wire logic                     ev_pfa_i,
  input  wire logic [3:0]               pfa_method_i,
  input  wire logic [$clog2(NINIT)-1:0] ev_issuer_i,
  // answer
  output logic                          rsp_valid_o,
  output sca_act_type                   rsp_act_o,
  output logic [7:0]                    rsp_status_o,
  output logic [3:0]                    rsp_sense_key_o,
  output logic [UA_KINDS-1:0]           rsp_ua_kind_o,
  output logic [NINIT-1:0]              ua_any_o
);

  localparam int IW = $clog2(NINIT);
  localparam int CW = $clog2(BLIM + 1);

  // the initiator index must land on a real slot for every code it can hold
  if (NINIT < 2) begin : g_chk_ninit
    $error("sca_admit: NINIT must be at least 2");
  end
  if ((1 << IW) != NINIT) begin : g_chk_pow2
    $error("sca_admit: NINIT must be a power of two");
  end
  if (QSIZE < 1) begin : g_chk_qsize
    $error("sca_admit: QSIZE must be positive");
  end
  if (BLIM < 1) begin : g_chk_blim
    $error("sca_admit: BLIM must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // attention event fan-out

  logic [NINIT-1:0]    others;
  logic [UA_KINDS-1:0] ua_set [NINIT];
  logic [NINIT-1:0]    ua_clr;
  logic [UA_KINDS-1:0] ua_pend [NINIT];
  logic [UA_KINDS-1:0] ua_top [NINIT];
  logic                mode_ok;
  logic                pfa_ok;

  assign others  = ~(NINIT'(1) << ev_issuer_i);
  // page data must really be written before the attention is owed
  assign mode_ok = ev_mode_set_i & ~ev_mode_err_i
                 & ~ev_mode_hdr_only_i;
  assign pfa_ok  = ev_pfa_i & (pfa_method_i == MRIE_UA);

  always_comb begin
    for (int i = 0; i < NINIT; i++) begin
      ua_set[i] = '0;
      ua_set[i][UA_RESET]   = ev_lun_reset_i;
      ua_set[i][UA_MODE]    = mode_ok & others[i];
      ua_set[i][UA_FORMAT]  = ev_format_done_i & others[i];
      ua_set[i][UA_MICRO]   = ev_micro_done_i & others[i];
      ua_set[i][UA_CLEARED] = ev_clear_task_i & others[i]
                            & ev_clear_mask_i[i];
      ua_set[i][UA_LOG]     = ev_log_clear_i & log_param_clear_bit_i
                            & others[i];
      ua_set[i][UA_PR_LOST] = ev_pr_lost_i
                            & (ev_holder_i == IW'(i));
      ua_set[i][UA_PFA]     = pfa_ok;
    end
  end

  for (genvar g = 0; g < NINIT; g++) begin : g_ua
    sca_ua_slot #(
      .KINDS (UA_KINDS)
    ) u_slot (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .set_i     (ua_set[g]),
      .clr_top_i (ua_clr[g]),
      .pend_o    (ua_pend[g]),
      .top_o     (ua_top[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // initiators seen since power on

  logic [CW-1:0]    seen_cnt_r;
  logic [NINIT-1:0] over_r;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      seen_cnt_r <= '0;
      over_r     <= '0;
    end else if (cmd_valid_i && cmd_new_init_i) begin
      if (seen_cnt_r < CW'(BLIM)) begin
        seen_cnt_r <= seen_cnt_r + CW'(1);
      end else begin
        over_r[cmd_init_i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // admission decision

  logic        ua_here;
  logic        over_here;
  logic        q_full;
  logic        tsf;
  sca_act_type act;
  logic [7:0]  st;
  logic [3:0]  sk;
  logic        clr_now;

  assign ua_here   = |ua_pend[cmd_init_i];
  assign over_here = over_r[cmd_init_i] | (cmd_new_init_i
                   & (seen_cnt_r >= CW'(BLIM)));
  assign q_full    = (q_used_i >= ($clog2(QSIZE)+1)'(QSIZE))
                   | (q_free_own_i == '0);
  assign tsf       = q_full | q_format_wait_i
                   | (degraded_i & q_start_wait_i);

  // walk the conditions highest first; the first hit decides
  always_comb begin
    act     = ACT_EXECUTE;
    st      = ST_GOOD;
    sk      = SK_NONE;
    clr_now = 1'b0;
    if (cmd_lun_bad_i) begin
      act = (cmd_kind_i == CMD_OTHER) ? ACT_CHECK : ACT_GOOD_NOEXEC;
      st  = (cmd_kind_i == CMD_OTHER) ? ST_CHECK : ST_GOOD;
      sk  = SK_ILLEGAL;
    end else if (cmd_bad_conn_i) begin
      act = ACT_CHECK;
      st  = ST_CHECK;
      sk  = SK_ILLEGAL;
    end else if (ua_here && cmd_kind_i != CMD_INQUIRY
                 && cmd_kind_i != CMD_REPORT_LUNS) begin
      if (cmd_kind_i == CMD_REQ_SENSE) begin
        act     = ACT_GOOD_NOEXEC;
        st      = ST_GOOD;
        sk      = cmd_sense_pend_i ? SK_NONE : SK_UNIT_ATTN;
        clr_now = ~cmd_sense_pend_i;
      end else begin
        act     = ACT_CHECK;
        st      = ST_CHECK;
        sk      = SK_UNIT_ATTN;
        clr_now = 1'b1;
      end
    end else if (over_here) begin
      act = ACT_BUSY;
      st  = ST_BUSY;
    end else if (io_active_i && !(cmd_priority_i && conc_ok_i) && tsf) begin
      act = ACT_TSF;
      st  = ST_TSF;
    end else if (cmd_deferred_i) begin
      act = ACT_CHECK;
      st  = ST_CHECK;
    end else if (not_ready_i && cmd_kind_i == CMD_OTHER) begin
      act = ACT_CHECK;
      st  = ST_CHECK;
      sk  = SK_NOT_READY;
    end else if (cmd_res_conf_i) begin
      act = ACT_RES_CONF;
      st  = ST_RES_CONF;
    end else if (cmd_bad_op_i || cmd_bad_cdb_i) begin
      act = ACT_CHECK;
      st  = ST_CHECK;
      sk  = SK_ILLEGAL;
    end else if (io_active_i && !(cmd_priority_i && conc_ok_i)) begin
      act = ACT_QUEUE;
    end else begin
      act = ACT_EXECUTE;
    end
  end

  always_comb begin
    ua_clr = '0;
    if (cmd_valid_i && clr_now) ua_clr[cmd_init_i] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered answer

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rsp_valid_o     <= 1'b0;
      rsp_act_o       <= ACT_EXECUTE;
      rsp_status_o    <= ST_GOOD;
      rsp_sense_key_o <= SK_NONE;
      rsp_ua_kind_o   <= '0;
    end else begin
      rsp_valid_o     <= cmd_valid_i;
      rsp_act_o       <= act;
      rsp_status_o    <= st;
      rsp_sense_key_o <= sk;
      rsp_ua_kind_o   <= clr_now ? ua_top[cmd_init_i] : '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ua_any_o <= '0;
    end else begin
      for (int i = 0; i < NINIT; i++) ua_any_o[i] <= |ua_pend[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_busy_code;
    @(posedge sys_clk_i) disable iff (reset_i)
    rsp_valid_o && rsp_act_o == ACT_BUSY |-> rsp_status_o == 8'h08;
  endproperty
  a_busy_code: assert property (p_busy_code)
    else $error("busy status byte wrong");

  property p_tsf_code;
    @(posedge sys_clk_i) disable iff (reset_i)
    rsp_valid_o && rsp_act_o == ACT_TSF |-> rsp_status_o == 8'h28;
  endproperty
  a_tsf_code: assert property (p_tsf_code)
    else $error("task set full status byte wrong");

  property p_ua_other;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && ua_here && !cmd_lun_bad_i && !cmd_bad_conn_i
      && cmd_kind_i == CMD_OTHER
      |=> rsp_status_o == 8'h02 && rsp_sense_key_o == SK_UNIT_ATTN;
  endproperty
  a_ua_other: assert property (p_ua_other)
    else $error("pending attention not reported");

  property p_inq_keeps;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && cmd_kind_i == CMD_INQUIRY && ua_here
      // ua_any_o lags a cycle, so look at the store itself
      |=> |ua_pend[$past(cmd_init_i)];
  endproperty
  a_inq_keeps: assert property (p_inq_keeps)
    else $error("inquiry cleared an attention");

  property p_not_ready;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && not_ready_i && ua_here && cmd_kind_i == CMD_OTHER
      && !cmd_lun_bad_i && !cmd_bad_conn_i
      |=> rsp_sense_key_o != SK_NOT_READY;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("not ready reported over attention");

  property p_reset_ua;
    @(posedge sys_clk_i) ev_lun_reset_i && !reset_i
      ##1 !reset_i |=> &ua_any_o;
  endproperty
  a_reset_ua: assert property (p_reset_ua)
    else $error("reset did not raise attention everywhere");

  property p_queue;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && io_active_i && !cmd_priority_i && !tsf && !ua_here
      && !over_here && !cmd_lun_bad_i && !cmd_bad_conn_i && !cmd_deferred_i
      && !not_ready_i && !cmd_res_conf_i && !cmd_bad_op_i && !cmd_bad_cdb_i
      |=> rsp_act_o == ACT_QUEUE;
  endproperty
  a_queue: assert property (p_queue)
    else $error("command not queued");

  property p_format_wait;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && io_active_i && q_format_wait_i && !cmd_priority_i
      && !ua_here && !over_here && !cmd_lun_bad_i && !cmd_bad_conn_i
      |=> rsp_act_o == ACT_TSF && rsp_status_o == 8'h28;
  endproperty
  a_format_wait: assert property (p_format_wait)
    else $error("queued format did not block the command");

  property p_queue_full;
    @(posedge sys_clk_i) disable iff (reset_i)
    cmd_valid_i && io_active_i && !cmd_priority_i && q_free_own_i == '0
      && !ua_here && !over_here && !cmd_lun_bad_i && !cmd_bad_conn_i
      |=> rsp_act_o == ACT_TSF;
  endproperty
  a_queue_full: assert property (p_queue_full)
    else $error("full queue did not give task set full");

  c_ua_clr: cover property (@(posedge sys_clk_i) rsp_ua_kind_o != '0);
  c_busy:  cover property (@(posedge sys_clk_i) rsp_act_o == ACT_BUSY);
  c_tsf:   cover property (@(posedge sys_clk_i) rsp_act_o == ACT_TSF);
  c_queue: cover property (@(posedge sys_clk_i) rsp_act_o == ACT_QUEUE);

endmodule : sca_admit

// ==== sca_host_model.sv ====
// behavioural initiator side: presents one command per request
`timescale 1ns/1ps
module sca_host_model
  import sca_pkg::*;
#(
  parameter int NINIT = NUM_INIT
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     go_i,
  input  wire logic [$clog2(NINIT)-1:0] init_i,
  input  wire sca_cmd_type              kind_i,
  output logic                          cmd_valid_o,
  output logic [$clog2(NINIT)-1:0]      cmd_init_o,
  output sca_cmd_type                   cmd_kind_o
);
  logic [$clog2(NINIT)-1:0] last_r = '0;
  sca_cmd_type              klast_r = CMD_OTHER;
  // idle lines show the inverse of the last value, never a stale copy
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      last_r  <= init_i;
      klast_r <= kind_i;
    end
  end
  assign cmd_valid_o = go_i;
  assign cmd_init_o  = go_i ? init_i : ~last_r;
  assign cmd_kind_o  = go_i ? kind_i : sca_cmd_type'(~klast_r);
endmodule : sca_host_model

// ==== sca_pkg.sv ====
// shared constants and types for the command admission unit
package sca_pkg;

  localparam int NUM_INIT       = 8;
  localparam int INIT_W         = 8;
  localparam int QUEUE_DEPTH    = 16;
  localparam int BUSY_LIMIT     = 64;
  localparam int UA_KINDS       = 8;

  // status byte codes
  localparam logic [7:0] ST_GOOD     = 8'h00;
  localparam logic [7:0] ST_CHECK    = 8'h02;
  localparam logic [7:0] ST_BUSY     = 8'h08;
  localparam logic [7:0] ST_RES_CONF = 8'h18;
  localparam logic [7:0] ST_TSF      = 8'h28;

  // sense keys
  localparam logic [3:0] SK_NONE      = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL   = 4'h5;
  localparam logic [3:0] SK_UNIT_ATTN = 4'h6;

  // reporting method that raises a failure prediction attention
  localparam logic [3:0] MRIE_UA      = 4'h2;

  // unit attention kinds, index 0 is the highest priority
  localparam int UA_RESET    = 0;
  localparam int UA_CLEARED  = 1;
  localparam int UA_PR_LOST  = 2;
  localparam int UA_FORMAT   = 3;
  localparam int UA_MICRO    = 4;
  localparam int UA_MODE     = 5;
  localparam int UA_LOG      = 6;
  localparam int UA_PFA      = 7;

  typedef enum logic [1:0] {
    CMD_INQUIRY,
    CMD_REPORT_LUNS,
    CMD_REQ_SENSE,
    CMD_OTHER
  } sca_cmd_type;

  typedef enum logic [2:0] {
    ACT_EXECUTE,
    ACT_QUEUE,
    ACT_CHECK,
    ACT_BUSY,
    ACT_TSF,
    ACT_RES_CONF,
    ACT_GOOD_NOEXEC
  } sca_act_type;

endpackage : sca_pkg

// ==== sca_ua_slot.sv ====
// per-initiator unit attention store with priority pick
`timescale 1ns/1ps
module sca_ua_slot
  import sca_pkg::*;
#(
  parameter int KINDS = UA_KINDS
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [KINDS-1:0] set_i,
  input  wire logic             clr_top_i,
  output logic      [KINDS-1:0] pend_o,
  output logic      [KINDS-1:0] top_o
);

  if (KINDS < 1) begin : g_chk_kinds
    $error("sca_ua_slot: KINDS must be positive");
  end

  logic [KINDS-1:0] pend_r;
  logic [KINDS-1:0] top_nxt;

  // lowest index wins, so one pick is always deterministic
  always_comb begin
    top_nxt = '0;
    for (int k = KINDS - 1; k >= 0; k--) begin
      if (pend_r[k]) top_nxt = KINDS'(1) << k;
    end
  end

  // set wins over clear so a fresh event is never lost
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pend_r <= KINDS'(1) << UA_RESET;
    end else begin
      pend_r <= (pend_r & ~(clr_top_i ? top_nxt : '0)) | set_i;
    end
  end

  assign pend_o = pend_r;
  assign top_o  = top_nxt;

endmodule : sca_ua_slot

// ==== tb.sv ====
// self-checking bench for the command admission unit
`timescale 1ns/1ps
module tb;
  import sca_pkg::*;
  localparam int NI = NUM_INIT;
  localparam int QS = QUEUE_DEPTH;
  localparam int BL = 4;  // short busy threshold keeps the run brief
  localparam int IW = $clog2(NI);
  localparam int QW = $clog2(QS) + 1;
  localparam logic [15:0] LUN = 16'h0001, CON = 16'h0002, SP = 16'h0004;
  localparam logic [15:0] DEF = 16'h0008, RC = 16'h0010, OP = 16'h0020;
  localparam logic [15:0] CDB = 16'h0040, IO = 16'h0080, CC = 16'h0100;
  localparam logic [15:0] PRI = 16'h0200, NR = 16'h0400, DEG = 16'h0800;
  localparam logic [15:0] FW = 16'h1000, SW = 16'h2000, NEW = 16'h4000;
  typedef struct {sca_act_type a; logic [7:0] s; logic [3:0] k;
                  logic [7:0] u;} sca_exp_type;
  sca_exp_type eq[$];
  int n_fail = 0, comparisons = 0;
  logic [31:0] seed = 32'h4126_186e;
  logic sys_clk_i = 0, reset_i = 1, go = 0;
  logic [IW-1:0] ini = '0;
  sca_cmd_type knd = CMD_OTHER;
  logic cmd_valid_i, cmd_new_init_i, cmd_priority_i, cmd_lun_bad_i;
  logic cmd_bad_conn_i, cmd_sense_pend_i, cmd_deferred_i, cmd_res_conf_i;
  logic cmd_bad_op_i, cmd_bad_cdb_i, io_active_i, conc_ok_i;
  logic q_format_wait_i, q_start_wait_i, degraded_i, not_ready_i;
  logic ev_lun_reset_i, ev_mode_set_i, ev_mode_err_i, ev_mode_hdr_only_i;
  logic ev_format_done_i, ev_micro_done_i, ev_log_clear_i, ev_pfa_i;
  logic log_param_clear_bit_i, ev_clear_task_i, ev_pr_lost_i;
  logic [IW-1:0] cmd_init_i, ev_holder_i, ev_issuer_i;
  sca_cmd_type cmd_kind_i;
  logic [QW-1:0] q_used_i = '0, q_free_own_i = '0;
  logic [NI-1:0] ev_clear_mask_i, ua_any_o;
  logic [3:0] pfa_method_i, rsp_sense_key_o;
  logic rsp_valid_o;
  sca_act_type rsp_act_o;
  logic [7:0] rsp_status_o;
  logic [UA_KINDS-1:0] rsp_ua_kind_o;
  logic [NI-1:0] m;
  int uk;

  always #20 sys_clk_i = ~sys_clk_i;

  sca_host_model #(.NINIT(NI)) host (.sys_clk_i, .go_i(go), .init_i(ini),
    .kind_i(knd), .cmd_valid_o(cmd_valid_i), .cmd_init_o(cmd_init_i),
    .cmd_kind_o(cmd_kind_i));
  sca_admit #(.NINIT(NI), .QSIZE(QS), .BLIM(BL)) dut (.sys_clk_i,
    .reset_i, .cmd_valid_i, .cmd_init_i, .cmd_new_init_i, .cmd_kind_i,
    .cmd_priority_i, .cmd_lun_bad_i, .cmd_bad_conn_i, .cmd_sense_pend_i,
    .cmd_deferred_i, .cmd_res_conf_i, .cmd_bad_op_i, .cmd_bad_cdb_i,
    .io_active_i, .conc_ok_i, .q_used_i, .q_free_own_i, .q_format_wait_i,
    .q_start_wait_i, .degraded_i, .not_ready_i, .ev_lun_reset_i,
    .ev_mode_set_i, .ev_mode_err_i, .ev_mode_hdr_only_i, .ev_format_done_i,
    .ev_micro_done_i, .ev_log_clear_i, .log_param_clear_bit_i,
    .ev_clear_task_i, .ev_clear_mask_i, .ev_pr_lost_i, .ev_holder_i,
    .ev_pfa_i, .pfa_method_i, .ev_issuer_i, .rsp_valid_o, .rsp_act_o,
    .rsp_status_o, .rsp_sense_key_o, .rsp_ua_kind_o, .ua_any_o);

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task automatic setf(input logic [15:0] f);
    {cmd_new_init_i, q_start_wait_i, q_format_wait_i, degraded_i,
     not_ready_i, cmd_priority_i, conc_ok_i, io_active_i, cmd_bad_cdb_i,
     cmd_bad_op_i, cmd_res_conf_i, cmd_deferred_i, cmd_sense_pend_i,
     cmd_bad_conn_i, cmd_lun_bad_i} = f[14:0];
  endtask : setf

  task automatic evclr();
    {ev_lun_reset_i, ev_mode_set_i, ev_mode_err_i, ev_mode_hdr_only_i,
     ev_format_done_i, ev_micro_done_i, ev_log_clear_i, ev_pfa_i,
     log_param_clear_bit_i, ev_clear_task_i, ev_pr_lost_i} = '0;
    ev_clear_mask_i = '0;
    pfa_method_i = 4'h0;
  endtask : evclr

  // sentinel ff / f skips status / sense where the answer leaves them open
  task automatic issue(input int i, input sca_cmd_type k,
    input logic [15:0] f, input int qu, input int qf, input sca_act_type a,
    input logic [7:0] st, input logic [3:0] sk, input int u);
    @(posedge sys_clk_i);
    #1;
    go = 1;
    ini = i[IW-1:0];
    knd = k;
    setf(f);
    q_used_i = qu[QW-1:0];
    q_free_own_i = qf[QW-1:0];
    eq.push_back('{a, st, sk, (u < 0) ? 8'h00 : 8'h01 << u});
  endtask : issue

  task automatic idle(input int n);
    @(posedge sys_clk_i);
    #1;
    go = 0;
    setf(16'h0000);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle

  task automatic anycmp(input logic [NI-1:0] x);
    @(negedge sys_clk_i);
    cmp(ua_any_o, x);
  endtask : anycmp

  task automatic fire(input int e, input int iss);
    logic [NI-1:0] ab;
    ab = ~(8'h01 << iss);
    idle(0);
    ev_issuer_i = iss[IW-1:0];
    m = '0;
    case (e)
      0: begin ev_lun_reset_i = 1; m = '1; uk = UA_RESET; end
      1: begin ev_mode_set_i = 1; m = ab; uk = UA_MODE; end
      2: begin ev_mode_set_i = 1; ev_mode_err_i = 1; end
      3: begin ev_mode_set_i = 1; ev_mode_hdr_only_i = 1; end
      4: begin ev_format_done_i = 1; m = ab; uk = UA_FORMAT; end
      5: begin ev_micro_done_i = 1; m = ab; uk = UA_MICRO; end
      6: begin
        ev_log_clear_i = 1; log_param_clear_bit_i = 1; m = ab; uk = UA_LOG;
      end
      7: ev_log_clear_i = 1;
      8: begin
        ev_clear_task_i = 1; ev_clear_mask_i = 8'(rnd());
        m = ev_clear_mask_i & ab; uk = UA_CLEARED;
      end
      9: begin
        ev_pr_lost_i = 1; ev_holder_i = 3'(iss + 1);
        m = 8'h01 << ev_holder_i; uk = UA_PR_LOST;
      end
      10: begin ev_pfa_i = 1; pfa_method_i = MRIE_UA; m = '1; uk = UA_PFA; end
      default: begin ev_pfa_i = 1; pfa_method_i = 4'h3; end
    endcase
    @(posedge sys_clk_i);
    #1;
    evclr();
  endtask : fire

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk_i) begin : mon
    sca_exp_type e;
    if (rsp_valid_o === 1'b1) begin
      if (eq.size() == 0) cmp(8'h00, 8'hff);  // answer with no command
      else begin
        e = eq.pop_front();
        cmp(8'(rsp_act_o), 8'(e.a));
        if (e.s !== 8'hff) cmp(rsp_status_o, e.s);
        if (e.k !== 4'hf) cmp(8'(rsp_sense_key_o), 8'(e.k));
        cmp(rsp_ua_kind_o, e.u);
      end
    end
  end

  initial begin : watchdog
    #(40 * 4000);
    n_fail++;
    stop_test();
  end

  initial begin : main
    int qu;
    setf(16'h0000);
    evclr();
    ev_holder_i = '0;
    ev_issuer_i = '0;
    repeat (10) @(posedge sys_clk_i);
    #1;
    reset_i = 0;
    repeat (2) @(posedge sys_clk_i);
    anycmp('1);
    issue(0, CMD_OTHER, LUN, 0, 1, ACT_CHECK, ST_CHECK, 4'hf, -1);
    issue(0, CMD_INQUIRY, LUN, 0, 1, ACT_GOOD_NOEXEC, ST_GOOD, SK_ILLEGAL, -1);
    issue(0, CMD_OTHER, CON, 0, 1, ACT_CHECK, ST_CHECK, 4'hf, -1);
    issue(0, CMD_INQUIRY, 0, 0, 1, ACT_EXECUTE, ST_GOOD, 4'hf, -1);
    issue(0, CMD_REPORT_LUNS, 0, 0, 1, ACT_EXECUTE, ST_GOOD, 4'hf, -1);
    issue(0, CMD_REQ_SENSE, SP, 0, 1, ACT_GOOD_NOEXEC, ST_GOOD, SK_NONE, -1);
    issue(1, CMD_OTHER, NR | IO, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, 0);
    issue(0, CMD_REQ_SENSE, 0, 0, 1, ACT_GOOD_NOEXEC, ST_GOOD, SK_UNIT_ATTN, 0);
    issue(2, CMD_OTHER, RC, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, 0);
    for (int i = 3; i < NI; i++)
      issue(i, CMD_OTHER, 0, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, 0);
    idle(1);
    anycmp('0);
    $display("test attention_pending done");
    qu = int'(rnd() % (QS - 1));
    issue(3, CMD_OTHER, 0, qu, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
    issue(3, CMD_OTHER, IO, qu, 1, ACT_QUEUE, 8'hff, 4'hf, -1);
    issue(3, CMD_OTHER, IO | PRI | CC, qu, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
    issue(3, CMD_OTHER, IO | PRI, qu, 1, ACT_QUEUE, 8'hff, 4'hf, -1);
    issue(3, CMD_OTHER, IO, QS, 1, ACT_TSF, ST_TSF, 4'hf, -1);
    issue(3, CMD_OTHER, IO, qu, 0, ACT_TSF, ST_TSF, 4'hf, -1);
    issue(3, CMD_OTHER, IO | FW, qu, 1, ACT_TSF, ST_TSF, 4'hf, -1);
    issue(3, CMD_OTHER, IO | DEG | SW, qu, 1, ACT_TSF, ST_TSF, 4'hf, -1);
    issue(3, CMD_OTHER, IO | SW, qu, 1, ACT_QUEUE, 8'hff, 4'hf, -1);
    issue(3, CMD_OTHER, IO | NR, qu, 1, ACT_CHECK, ST_CHECK, SK_NOT_READY, -1);
    issue(3, CMD_OTHER, NR | DEF, qu, 1, ACT_CHECK, ST_CHECK, SK_NONE, -1);
    issue(3, CMD_OTHER, IO | FW | DEF, qu, 1, ACT_TSF, ST_TSF, 4'hf, -1);
    issue(3, CMD_OTHER, NR | RC, qu, 1, ACT_CHECK, ST_CHECK, SK_NOT_READY, -1);
    issue(3, CMD_OTHER, RC | OP, qu, 1, ACT_RES_CONF, ST_RES_CONF, 4'hf, -1);
    issue(3, CMD_OTHER, OP | CDB, qu, 1, ACT_CHECK, ST_CHECK, 4'hf, -1);
    issue(3, CMD_OTHER, CON | IO, QS, 1, ACT_CHECK, ST_CHECK, 4'hf, -1);
    idle(1);
    $display("test admission done");
    for (int e = 0; e < 12; e++) begin
      fire(e, int'(rnd() % NI));
      for (int i = 0; i < NI; i++)
        if (m[i])
          issue(i, CMD_OTHER, 0, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, uk);
        else
          issue(i, CMD_OTHER, 0, 0, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
      idle(1);
      anycmp('0);
    end
    $display("test attention_events done");
    for (int i = 0; i < BL; i++)
      issue(i, CMD_OTHER, NEW, 0, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
    issue(BL, CMD_OTHER, NEW, 0, 1, ACT_BUSY, ST_BUSY, 4'hf, -1);
    issue(BL, CMD_OTHER, 0, 0, 1, ACT_BUSY, ST_BUSY, 4'hf, -1);
    issue(0, CMD_OTHER, 0, 0, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
    $display("test busy done");
    fire(5, 0);
    fire(4, 0);
    issue(1, CMD_OTHER, 0, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, UA_FORMAT);
    issue(1, CMD_OTHER, 0, 0, 1, ACT_CHECK, ST_CHECK, SK_UNIT_ATTN, UA_MICRO);
    issue(1, CMD_OTHER, 0, 0, 1, ACT_EXECUTE, 8'hff, 4'hf, -1);
    idle(3);
    cmp(8'(eq.size()), 8'h00);
    $display("test accumulate done");
    stop_test();
  end
endmodule : tb
